// ### inc/pdd_regs.vh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   included by the engine; definitions only
`ifndef PDD_REGS_VH
`define PDD_REGS_VH

// register byte offsets
`define PDD_CTRL_OFS      12'h000
`define PDD_STAT_OFS      12'h004
`define PDD_IDIV_OFS      12'h008
`define PDD_ODIV_OFS      12'h00c
`define PDD_CDIV_OFS      12'h010
`define PDD_OLEN_OFS      12'h014
`define PDD_ILEN_OFS      12'h018
`define PDD_OCNT_OFS      12'h01c
`define PDD_ICNT_OFS      12'h020
`define PDD_OVR_OFS       12'h024
`define PDD_IRQS_OFS      12'h028
`define PDD_IRQM_OFS      12'h02c
`define PDD_OBASE_OFS     12'h030
`define PDD_IBASE_OFS     12'h034

// control fields
`define PDD_C_OSTART      0
`define PDD_C_OSTOP       1
`define PDD_C_ISTART      2
`define PDD_C_ISTOP       3
`define PDD_C_ICHAIN      4
`define PDD_C_OCHAIN      5
`define PDD_C_DBL         6
`define PDD_C_OCONT       7
`define PDD_C_ISRC_LO     8
`define PDD_C_ISRC_HI     9
`define PDD_C_RELOAD      10

// input clock sources
`define PDD_SRC_PACER     2'h0
`define PDD_SRC_EXT       2'h1
`define PDD_SRC_HSK       2'h2

// status / irq fields
`define PDD_S_ORUN        0
`define PDD_S_IRUN        1
`define PDD_S_HALF        2
`define PDD_S_HALFSEL     3
`define PDD_I_ODONE       0
`define PDD_I_IDONE       1
`define PDD_I_HALF        2
`define PDD_I_OVR         3
`define PDD_IRQ_W         4

// reset values and divisor floor
`define PDD_DIV_RST       16'hffff
`define PDD_DIV_MIN       16'h0002
// 64 mbyte limit in 4-byte samples
`define PDD_LEN_MAX       32'h0100_0000
// reference 4 mhz derived from the 25 mhz system clock in khz
`define PDD_SYS_KHZ       25000
`define PDD_REF_KHZ       4000
`define PDD_ACC_W         16
`endif

// ### rtl/pdd_engine.v
// Purpose: pacer-timed digital i/o dma engine with double-buffered input
// Assumes: single 25 mhz clock, apb register slave, simple dma master port
// Notes:   sample data paths stay outside; this block issues addresses
`timescale 1ns/1ns
`include "pdd_regs.vh"

module pdd_engine #(
  parameter DIV_W = 16
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  input  wire [11:0] i_paddr,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_ext_clk,
  input  wire        i_in_req,
  output reg         o_in_ack,
  output reg         o_dma_wr,
  output reg         o_dma_rd,
  output reg  [31:0] o_dma_addr,
  input  wire        i_dma_done,
  output reg         o_out_strobe,
  output reg         o_irq
);

  // registers
  reg [31:0] ctrl_r;
  reg [DIV_W-1:0] idiv_r, odiv_r, cdiv_r;
  reg [31:0] olen_r, ilen_r, ocnt_r, icnt_r, ovr_r, obase_r, ibase_r;
  reg [`PDD_IRQ_W-1:0] irqs_r, irqm_r;
  reg orun_r, irun_r, half_rdy_r, half_sel_r;
  reg [31:0] half_pos_r;
  reg ext_d_r, in_pend_r, out_pend_r;

  // divider state
  reg [15:0] ref_acc_r;
  reg ref_tick_r;
  reg [DIV_W-1:0] icnt0_r, ocnt1_r, ccnt2_r;
  reg ichain_r, ochain_r;
  reg i_strobe_r, o_strobe_r;

  wire apb_acc = i_psel & i_penable;
  wire apb_wr  = apb_acc & i_pwrite;
  wire [31:0] wmask = {{(32-`PDD_IRQ_W){1'b0}}, irqs_r};

  // clamp a divisor to the legal floor
  function [DIV_W-1:0] clamp_div;
    input [DIV_W-1:0] v;
    begin
      clamp_div = (v < `PDD_DIV_MIN) ? `PDD_DIV_MIN : v;
    end
  endfunction

  wire wr_ctrl = apb_wr && i_paddr == `PDD_CTRL_OFS;
  wire reload  = wr_ctrl && i_pwdata[`PDD_C_RELOAD];
  wire c2_tick = ref_tick_r && ccnt2_r == {{(DIV_W-1){1'b0}}, 1'b1};
  wire i_src   = ichain_r ? c2_tick : ref_tick_r;
  wire o_src   = ochain_r ? c2_tick : ref_tick_r;
  wire i_hit   = i_src && icnt0_r == {{(DIV_W-1){1'b0}}, 1'b1};
  wire o_hit   = o_src && ocnt1_r == {{(DIV_W-1){1'b0}}, 1'b1};
  wire [1:0] isrc = ctrl_r[`PDD_C_ISRC_HI:`PDD_C_ISRC_LO];
  wire ext_rise = i_ext_clk & ~ext_d_r;
  wire in_evt = (isrc == `PDD_SRC_PACER) ? i_strobe_r :
                (isrc == `PDD_SRC_EXT)   ? ext_rise :
                (isrc == `PDD_SRC_HSK)   ? (i_in_req & ~o_in_ack) : 1'b0;
  wire [31:0] half_len = {1'b0, ilen_r[31:1]};
  // word index of the input sample being written
  wire [31:0] in_idx   = half_sel_r ? half_len + half_pos_r :
                         (ctrl_r[`PDD_C_DBL] ? half_pos_r : icnt_r);
  // accumulator sum kept 32 bits wide, cut back to 16 on purpose
  wire [31:0] ref_sum  = {16'h0000, ref_acc_r} + `PDD_REF_KHZ;
  wire [31:0] ref_wrap = ref_sum - `PDD_SYS_KHZ;

  // 4 mhz reference enable from 25 mhz by fractional accumulation
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_acc_r  <= 16'h0000;
      ref_tick_r <= 1'b0;
    end else if (ref_sum >= `PDD_SYS_KHZ) begin
      ref_acc_r  <= ref_wrap[15:0];
      ref_tick_r <= 1'b1;
    end else begin
      ref_acc_r  <= ref_sum[15:0];
      ref_tick_r <= 1'b0;
    end
  end

  // cascaded down-counters; chain setting latched only on reload
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      icnt0_r    <= `PDD_DIV_RST;
      ocnt1_r    <= `PDD_DIV_RST;
      ccnt2_r    <= `PDD_DIV_RST;
      ichain_r   <= 1'b0;
      ochain_r   <= 1'b0;
      i_strobe_r <= 1'b0;
      o_strobe_r <= 1'b0;
    end else if (reload) begin
      icnt0_r    <= clamp_div(idiv_r);
      ocnt1_r    <= clamp_div(odiv_r);
      ccnt2_r    <= clamp_div(cdiv_r);
      ichain_r   <= i_pwdata[`PDD_C_ICHAIN];
      ochain_r   <= i_pwdata[`PDD_C_OCHAIN];
      i_strobe_r <= 1'b0;
      o_strobe_r <= 1'b0;
    end else begin
      if (ref_tick_r)
        ccnt2_r <= c2_tick ? clamp_div(cdiv_r) : ccnt2_r - 1'b1;
      if (i_src)
        icnt0_r <= i_hit ? clamp_div(idiv_r) : icnt0_r - 1'b1;
      if (o_src)
        ocnt1_r <= o_hit ? clamp_div(odiv_r) : ocnt1_r - 1'b1;
      i_strobe_r <= i_hit; // one cycle per period
      o_strobe_r <= o_hit;
    end
  end

  // apb slave: zero wait, reads registered in setup phase
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      if (i_psel & ~i_penable) begin
        case (i_paddr)
          `PDD_CTRL_OFS:  o_prdata <= ctrl_r;
          `PDD_STAT_OFS:  o_prdata <= {28'h0, half_sel_r, half_rdy_r, irun_r, orun_r};
          `PDD_IDIV_OFS:  o_prdata <= {16'h0, idiv_r};
          `PDD_ODIV_OFS:  o_prdata <= {16'h0, odiv_r};
          `PDD_CDIV_OFS:  o_prdata <= {16'h0, cdiv_r};
          `PDD_OLEN_OFS:  o_prdata <= olen_r;
          `PDD_ILEN_OFS:  o_prdata <= ilen_r;
          `PDD_OCNT_OFS:  o_prdata <= ocnt_r;
          `PDD_ICNT_OFS:  o_prdata <= icnt_r;
          `PDD_OVR_OFS:   o_prdata <= ovr_r;
          `PDD_IRQS_OFS:  o_prdata <= wmask;
          `PDD_IRQM_OFS:  o_prdata <= {28'h0, irqm_r};
          `PDD_OBASE_OFS: o_prdata <= obase_r;
          `PDD_IBASE_OFS: o_prdata <= ibase_r;
          default: begin
            o_prdata  <= 32'h0000_0000;
          end
        endcase
        o_pslverr <= 1'b0;
      end
    end
  end

  // software-written configuration
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r  <= 32'h0000_0000;
      idiv_r  <= `PDD_DIV_RST;
      odiv_r  <= `PDD_DIV_RST;
      cdiv_r  <= `PDD_DIV_RST;
      olen_r  <= 32'h0000_0000;
      ilen_r  <= 32'h0000_0000;
      obase_r <= 32'h0000_0000;
      ibase_r <= 32'h0000_0000;
      irqm_r  <= {`PDD_IRQ_W{1'b0}};
    end else if (apb_wr) begin
      case (i_paddr)
        `PDD_CTRL_OFS:  ctrl_r  <= i_pwdata & 32'h0000_03f0; // commands self-clear
        `PDD_IDIV_OFS:  idiv_r  <= i_pwdata[DIV_W-1:0];
        `PDD_ODIV_OFS:  odiv_r  <= i_pwdata[DIV_W-1:0];
        `PDD_CDIV_OFS:  cdiv_r  <= i_pwdata[DIV_W-1:0];
        `PDD_OLEN_OFS:  olen_r  <= (i_pwdata > `PDD_LEN_MAX) ? `PDD_LEN_MAX : i_pwdata;
        `PDD_ILEN_OFS:  ilen_r  <= (i_pwdata > `PDD_LEN_MAX) ? `PDD_LEN_MAX : i_pwdata;
        `PDD_OBASE_OFS: obase_r <= {i_pwdata[31:2], 2'b00};
        `PDD_IBASE_OFS: ibase_r <= {i_pwdata[31:2], 2'b00};
        `PDD_IRQM_OFS:  irqm_r  <= i_pwdata[`PDD_IRQ_W-1:0];
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // output dma: one word fetched per strobe, stop wins at once
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      orun_r       <= 1'b0;
      ocnt_r       <= 32'h0000_0000;
      out_pend_r   <= 1'b0;
      o_dma_rd     <= 1'b0;
      o_out_strobe <= 1'b0;
    end else begin
      o_out_strobe <= 1'b0;
      if (wr_ctrl && i_pwdata[`PDD_C_OSTOP]) begin
        orun_r     <= 1'b0; // count left as is
        out_pend_r <= 1'b0;
        o_dma_rd   <= 1'b0;
      end else if (wr_ctrl && i_pwdata[`PDD_C_OSTART] && olen_r != 32'h0) begin
        orun_r <= 1'b1;
        ocnt_r <= 32'h0000_0000;
      end else if (orun_r) begin
        if (o_strobe_r && !out_pend_r) begin
          out_pend_r <= 1'b1;
          o_dma_rd   <= 1'b1;
        end
        if (out_pend_r && i_dma_done) begin
          out_pend_r   <= 1'b0;
          o_dma_rd     <= 1'b0;
          o_out_strobe <= 1'b1;
          if (ocnt_r + 1'b1 >= olen_r) begin
            if (ctrl_r[`PDD_C_OCONT])
              ocnt_r <= 32'h0000_0000; // wrap to buffer start
            else begin
              ocnt_r <= ocnt_r + 1'b1;
              orun_r <= 1'b0; // terminal count
            end
          end else
            ocnt_r <= ocnt_r + 1'b1;
        end
      end
    end
  end

  // input dma with optional circular double buffer
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irun_r     <= 1'b0;
      icnt_r     <= 32'h0000_0000;
      half_pos_r <= 32'h0000_0000;
      half_sel_r <= 1'b0;
      half_rdy_r <= 1'b0;
      ovr_r      <= 32'h0000_0000;
      in_pend_r  <= 1'b0;
      o_dma_wr   <= 1'b0;
      o_in_ack   <= 1'b0;
      ext_d_r    <= 1'b0;
    end else begin
      ext_d_r  <= i_ext_clk;
      o_in_ack <= o_in_ack & i_in_req; // drop once request released
      if (apb_wr && i_paddr == `PDD_IRQS_OFS && i_pwdata[`PDD_I_HALF])
        half_rdy_r <= 1'b0; // host drained the ready half
      if (wr_ctrl && i_pwdata[`PDD_C_ISTOP]) begin
        irun_r    <= 1'b0;
        in_pend_r <= 1'b0;
        o_dma_wr  <= 1'b0;
      end else if (wr_ctrl && i_pwdata[`PDD_C_ISTART] && ilen_r != 32'h0) begin
        irun_r     <= 1'b1;
        icnt_r     <= 32'h0000_0000;
        half_pos_r <= 32'h0000_0000;
        half_sel_r <= 1'b0;
        half_rdy_r <= 1'b0;
      end else if (irun_r) begin
        if (in_evt && !in_pend_r) begin
          in_pend_r <= 1'b1;
          o_dma_wr  <= 1'b1;
          if (isrc == `PDD_SRC_HSK)
            o_in_ack <= 1'b1;
        end
        if (in_pend_r && i_dma_done) begin
          in_pend_r <= 1'b0;
          o_dma_wr  <= 1'b0;
          icnt_r    <= icnt_r + 1'b1;
          if (ctrl_r[`PDD_C_DBL]) begin
            if (half_pos_r + 1'b1 >= half_len) begin
              half_pos_r <= 32'h0000_0000;
              half_sel_r <= ~half_sel_r; // first, second, wrap
              half_rdy_r <= 1'b1;
              if (half_rdy_r)
                ovr_r <= ovr_r + 1'b1;
            end else
              half_pos_r <= half_pos_r + 1'b1;
          end else if (icnt_r + 1'b1 >= ilen_r)
            irun_r <= 1'b0;
        end
      end
    end
  end

  // dma word address and interrupt status
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dma_addr <= 32'h0000_0000;
      irqs_r     <= {`PDD_IRQ_W{1'b0}};
      o_irq      <= 1'b0;
    end else begin
      if (o_dma_wr)
        o_dma_addr <= ibase_r + {in_idx[29:0], 2'b00};
      else
        o_dma_addr <= obase_r + {ocnt_r[29:0], 2'b00};
      // set wins over write-one-to-clear
      irqs_r <= (irqs_r & ~((apb_wr && i_paddr == `PDD_IRQS_OFS) ?
                i_pwdata[`PDD_IRQ_W-1:0] : {`PDD_IRQ_W{1'b0}})) |
                {(in_pend_r && i_dma_done && ctrl_r[`PDD_C_DBL] &&
                  half_pos_r + 1'b1 >= half_len && half_rdy_r),
                 (in_pend_r && i_dma_done && ctrl_r[`PDD_C_DBL] &&
                  half_pos_r + 1'b1 >= half_len),
                 (irun_r && in_pend_r && i_dma_done && !ctrl_r[`PDD_C_DBL] &&
                  icnt_r + 1'b1 >= ilen_r),
                 (orun_r && out_pend_r && i_dma_done && !ctrl_r[`PDD_C_OCONT] &&
                  ocnt_r + 1'b1 >= olen_r)};
      o_irq <= |(irqs_r & irqm_r);
    end
  end

endmodule // pdd_engine

// ### tb/pdd_asserts.sv
// Purpose: port checks for the dio dma engine
// Assumes: one clock, async active-low reset
// Notes:   bound into every engine instance
`timescale 1ns/1ns
`include "pdd_regs.vh"
module pdd_asserts (
  input wire        i_clk_sys,
  input wire        i_rst_b,
  input wire [11:0] i_paddr,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        i_ext_clk,
  input wire        i_in_req,
  input wire        o_in_ack,
  input wire        o_dma_wr,
  input wire        o_dma_rd,
  input wire [31:0] o_dma_addr,
  input wire        i_dma_done,
  input wire        o_out_strobe,
  input wire        o_irq
);
  // command writes that end or restart a pending word on purpose
  wire ctrl_wr = i_psel && i_penable && i_pwrite && i_paddr == `PDD_CTRL_OFS;
  wire out_cmd = ctrl_wr && (i_pwdata[`PDD_C_OSTOP] || i_pwdata[`PDD_C_OSTART]);
  wire in_cmd  = ctrl_wr && (i_pwdata[`PDD_C_ISTOP] || i_pwdata[`PDD_C_ISTART]);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // bus setup phase and word hand-off steps
  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_rd_done; o_dma_rd && i_dma_done && !out_cmd; endsequence
  sequence s_wr_done; o_dma_wr && i_dma_done && !in_cmd; endsequence
  a_apb_zero_wait: assert property (s_setup |=> o_pready)
    else $error("pready late");
  a_no_slverr: assert property (!o_pslverr)
    else $error("pslverr raised");
  a_rdata_stands: assert property ($changed(o_prdata) |-> $past(i_psel && !i_penable))
    else $error("prdata moved outside setup");
  a_rd_holds: assert property (o_dma_rd && !i_dma_done && !out_cmd |=> o_dma_rd)
    else $error("read dropped early");
  a_wr_holds: assert property (o_dma_wr && !i_dma_done && !in_cmd |=> o_dma_wr)
    else $error("write dropped early");
  a_rd_strobe: assert property (s_rd_done |=> !o_dma_rd && o_out_strobe)
    else $error("no strobe after read");
  a_wr_clears: assert property (s_wr_done |=> !o_dma_wr)
    else $error("write stuck");
  a_strobe_cause: assert property (o_out_strobe |-> $past(o_dma_rd && i_dma_done))
    else $error("strobe without word");
  a_strobe_single: assert property (o_out_strobe |=> !o_out_strobe)
    else $error("strobe too long");
  a_ack_after_req: assert property ($fell(o_in_ack) |-> !$past(i_in_req))
    else $error("ack fell early");
endmodule // pdd_asserts

bind pdd_engine pdd_asserts u_chk (.i_clk_sys, .i_rst_b, .i_paddr, .i_psel, .i_penable,
  .i_pwrite, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_ext_clk, .i_in_req, .o_in_ack,
  .o_dma_wr, .o_dma_rd, .o_dma_addr, .i_dma_done, .o_out_strobe, .o_irq);

// ### tb/pdd_host_mem.sv
// Purpose: host bus and memory model, one word at a time
// Assumes: done is a one-cycle pulse per pending word
// Notes:   latency set live; counts words served
`timescale 1ns/1ns
module pdd_host_mem (
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  input  wire        i_dma_wr,
  input  wire        i_dma_rd,
  input  wire [3:0]  i_lat,
  output reg         o_dma_done,
  output reg  [15:0] o_n_word
);
  reg [3:0] wait_r;
  // idle one cycle after done so a clearing request is not answered twice
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dma_done <= 1'b0;
      wait_r     <= 4'h0;
      o_n_word   <= 16'h0000;
    end else if (o_dma_done) begin
      o_dma_done <= 1'b0;
      wait_r     <= 4'h0;
    end else if ((i_dma_wr || i_dma_rd) && wait_r == i_lat) begin
      o_dma_done <= 1'b1;
      o_n_word   <= o_n_word + 16'h0001;
    end else if (i_dma_wr || i_dma_rd) begin
      wait_r     <= wait_r + 4'h1;
    end else begin
      wait_r     <= 4'h0; // a request dropped by stop leaves no stale wait
    end
  end
endmodule // pdd_host_mem

// ### tb/tb_top.sv
// Purpose: self-checking bench for the dio dma engine
// Assumes: host model answers each word
// Notes:   pacer rates judged over a window with one sample slack
`timescale 1ns/1ns
`include "pdd_regs.vh"
module tb_top;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg         ext_clk = 1'b0;
  reg         in_req = 1'b0;
  reg  [3:0]  lat = 4'h0;
  reg  [31:0] q;
  reg  [15:0] a0;
  reg  [31:0] last_addr = 32'h0;
  wire [31:0] prdata;
  wire [31:0] dma_addr;
  wire [15:0] n_word;
  wire        pready, pslverr, in_ack, dma_wr, dma_rd, dma_done, out_strobe, irq;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     i;
  // 25 mhz system clock
  initial forever #20 clk = ~clk;
  pdd_engine dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_clk(ext_clk), .i_in_req(in_req),
    .o_in_ack(in_ack), .o_dma_wr(dma_wr), .o_dma_rd(dma_rd), .o_dma_addr(dma_addr),
    .i_dma_done(dma_done), .o_out_strobe(out_strobe), .o_irq(irq));
  pdd_host_mem u_mem (.i_clk_sys(clk), .i_rst_b(rst_b), .i_dma_wr(dma_wr), .i_dma_rd(dma_rd),
    .i_lat(lat), .o_dma_done(dma_done), .o_n_word(n_word));
  // address of the word the host answered last
  always @(posedge clk)
    if (dma_done) last_addr <= dma_addr;
  task stop_test;
    begin
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // exact when lo equals hi; an unknown never matches
  task chk(input [8*8:1] nm, input [31:0] lo, input [31:0] hi, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if ((got !== lo) && ((^got === 1'bx) || got < lo || got > hi)) begin
        $display("[ERR] %0s exp %h..%h got %h", nm, lo, hi, got);
        n_errors = n_errors + 1;
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; read data taken at the pready edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input [11:0] a, input [31:0] m, input [31:0] lo, input [31:0] hi, input [8*8:1] nm);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, lo, hi, q & m);
    end
  endtask
  task words(input [31:0] n);
    chk("words", n, n, {16'h0000, n_word - a0});
  endtask
  // external sample clock pulses, slow enough for each word to land
  task pulse(input integer n);
    repeat (n) begin
      ext_clk <= 1'b1;
      wt(4);
      ext_clk <= 1'b0;
      wt(16);
    end
  endtask
  task t_reset;
    begin
      rdc(`PDD_IDIV_OFS, 32'hffff, 32'hffff, 32'hffff, "idiv");
      rdc(`PDD_ODIV_OFS, 32'hffff, 32'hffff, 32'hffff, "odiv");
      rdc(`PDD_CDIV_OFS, 32'hffff, 32'hffff, 32'hffff, "cdiv");
      rdc(`PDD_STAT_OFS, 32'hf, 32'h0, 32'h0, "stat");
      rdc(`PDD_OVR_OFS, 32'hffff_ffff, 32'h0, 32'h0, "ovr");
      apb(1'b1, 12'h0fc, 32'h5a5a_5a5a);
      rdc(12'h0fc, 32'hffff_ffff, 32'h0, 32'h0, "unmap");
    end
  endtask
  task t_oneshot;
    begin
      lat <= 4'h5;
      apb(1'b1, `PDD_ODIV_OFS, 32'h2);
      apb(1'b1, `PDD_OBASE_OFS, 32'h2000);
      apb(1'b1, `PDD_CTRL_OFS, 32'h400);
      apb(1'b1, `PDD_OLEN_OFS, 32'h5);
      apb(1'b1, `PDD_IRQM_OFS, 32'h1);
      a0 = n_word;
      apb(1'b1, `PDD_CTRL_OFS, 32'h1);
      rdc(`PDD_STAT_OFS, 32'h1, 32'h1, 32'h1, "orun");
      for (i = 0; i < 200 && q[0] === 1'b1; i = i + 1) apb(1'b0, `PDD_STAT_OFS, 32'h0);
      chk("odone", 0, 0, q & 32'h1);
      rdc(`PDD_OCNT_OFS, 32'hffff_ffff, 32'h5, 32'h5, "ocnt");
      wt(300);
      words(5);
      chk("oaddr", 32'h2010, 32'h2010, last_addr);
      chk("irq", 1, 1, {31'h0, irq});
      apb(1'b1, `PDD_IRQS_OFS, 32'hf);
      wt(2);
      chk("irqclr", 0, 0, {31'h0, irq});
    end
  endtask
  // divisor and chain loaded with reload, then a timed window of samples
  task t_rate(input [11:0] da, input [31:0] d, input [31:0] cfg, input [31:0] go,
              input [31:0] lo, input [31:0] hi);
    begin
      lat <= 4'h0;
      apb(1'b1, da, d);
      apb(1'b1, `PDD_CDIV_OFS, 32'h5);
      apb(1'b1, `PDD_CTRL_OFS, cfg | 32'h400);
      apb(1'b1, `PDD_CTRL_OFS, cfg | go);
      a0 = n_word;
      wt(2500);
      chk("rate", lo, hi, {16'h0000, n_word - a0});
      apb(1'b1, `PDD_CTRL_OFS, cfg | (go << 1));
      rdc(`PDD_STAT_OFS, 32'h3, 32'h0, 32'h0, "stopped");
    end
  endtask
  task t_ext;
    begin
      lat <= 4'h2;
      apb(1'b1, `PDD_CTRL_OFS, 32'h100);
      apb(1'b1, `PDD_CTRL_OFS, 32'h104);
      a0 = n_word;
      pulse(6);
      words(6);
      apb(1'b1, `PDD_CTRL_OFS, 32'h108);
    end
  endtask
  task t_hsk;
    begin
      apb(1'b1, `PDD_CTRL_OFS, 32'h200);
      apb(1'b1, `PDD_CTRL_OFS, 32'h204);
      a0 = n_word;
      repeat (3) begin
        in_req <= 1'b1;
        for (i = 0; i < 100 && in_ack !== 1'b1; i = i + 1) wt(1);
        chk("ack", 1, 1, {31'h0, in_ack});
        in_req <= 1'b0;
        for (i = 0; i < 100 && in_ack !== 1'b0; i = i + 1) wt(1);
      end
      wt(10);
      words(3);
      apb(1'b1, `PDD_CTRL_OFS, 32'h208);
    end
  endtask
  task t_dbl;
    begin
      apb(1'b1, `PDD_ILEN_OFS, 32'h4);
      apb(1'b1, `PDD_IBASE_OFS, 32'h1000);
      apb(1'b1, `PDD_CTRL_OFS, 32'h140);
      apb(1'b1, `PDD_CTRL_OFS, 32'h144);
      a0 = n_word;
      pulse(3);
      rdc(`PDD_STAT_OFS, 32'hc, 32'hc, 32'hc, "half");
      rdc(`PDD_IRQS_OFS, 32'h4, 32'h4, 32'h4, "halfirq");
      pulse(4);
      words(7);
      chk("iaddr", 32'h1008, 32'h1008, last_addr);
      rdc(`PDD_OVR_OFS, 32'hffff_ffff, 32'h2, 32'h2, "ovr");
      apb(1'b1, `PDD_CTRL_OFS, 32'h148);
    end
  endtask
  // main sequence
  initial begin
    wt(20);
    rst_b <= 1'b1;
    wt(1);
    t_reset;
    t_oneshot;
    apb(1'b1, `PDD_OLEN_OFS, 32'h3);
    apb(1'b1, `PDD_ILEN_OFS, 32'd1000);
    t_rate(`PDD_ODIV_OFS, 32'd10, 32'h80, 32'h1, 39, 41);
    t_rate(`PDD_ODIV_OFS, 32'd5, 32'ha0, 32'h1, 15, 17);
    t_rate(`PDD_IDIV_OFS, 32'd10, 32'h0, 32'h4, 39, 41);
    t_rate(`PDD_IDIV_OFS, 32'd5, 32'h10, 32'h4, 15, 17);
    t_ext;
    t_hsk;
    t_dbl;
    stop_test;
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    #(40 * 60000);
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule // tb_top
